// ==== design/bus_reset_defines.svh ====
// Purpose: offsets, field positions, packet layout and reset values of the bus-reset block
// Assumes: included by bare name from the design files
// Notes: contract of the bus-reset block
`ifndef BUS_RESET_DEFINES_SVH
`define BUS_RESET_DEFINES_SVH

// register byte offsets
`define OFS_RUN_CTRL     12'h000
`define OFS_CTX_STATUS   12'h004
`define OFS_INT_EVENT    12'h008
`define OFS_INT_MASK     12'h00c
`define OFS_NODE_ID      12'h010
`define OFS_SELF_ID_CNT  12'h014

// context bit positions in run, active and status fields
`define CTX_AT_REQ       0
`define CTX_AT_RSP       1
`define CTX_AR_REQ       2
`define STAT_FLUSHING    4
`define STAT_PKT_PEND    5

// event bit positions
`define EV_BUS_RESET     0
`define EV_REQ_PKT       1

// node id and self id count fields
`define NODE_VALID_BIT   31
`define NODE_NUM_LSB     0
`define SIDC_GEN_LSB     16

// bus-reset packet layout
`define BRP_TCODE        4'he
`define BRP_TCODE_LSB    4
`define BRP_EVT_LSB      16
`define BRP_GEN_LSB      0

// reset values
`define RST_RUN          3'h0
`define RST_MASK         2'h0

`endif

// ==== design/bus_reset_pkg.sv ====
// Purpose: shared types of the bus-reset block
// Assumes: nothing
// Notes: constants live in bus_reset_defines.svh
package bus_reset_pkg;
	typedef logic [31:0] quadlet_t;
	typedef logic [7:0]  generation_t;
	typedef logic [4:0]  evt_code_t;
	typedef enum logic [1:0] {
		GEN_IDLE,
		GEN_HEAD,
		GEN_TAIL
	} gen_state_t;
endpackage : bus_reset_pkg

// ==== design/brp_if.sv ====
// Purpose: start handshake between context logic and the bus-reset packet builder
// Assumes: one clock
// Notes: start is a one-cycle pulse taken only while busy is low
`timescale 1ns/1ps
`default_nettype none
interface brp_if;
	logic                      start;
	bus_reset_pkg::generation_t generation;
	bus_reset_pkg::evt_code_t  evt_code;
	logic                      busy;
	modport ctx (output start, output generation, output evt_code, input busy);
	modport gen (input start, input generation, input evt_code, output busy);
endinterface : brp_if
`default_nettype wire

// ==== design/bus_reset_packet_gen.sv ====
// Purpose: emits the two-quadlet synthesized bus-reset packet into the receive FIFO
// Assumes: rx_ready is the receive FIFO's space indication
// Notes: a quadlet is held until the FIFO takes it
`include "bus_reset_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module bus_reset_packet_gen (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	brp_if.gen                           ctl,
	input  wire logic                    rx_ready,
	output var  logic                    rx_valid,
	output var  bus_reset_pkg::quadlet_t rx_data,
	output var  logic                    rx_last
);
	bus_reset_pkg::gen_state_t state_r;
	bus_reset_pkg::quadlet_t   tail_r;
	wire                       take;

	assign take     = rx_valid & rx_ready;
	assign ctl.busy = (state_r != bus_reset_pkg::GEN_IDLE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r  <= bus_reset_pkg::GEN_IDLE;
			rx_valid <= 1'b0;
			rx_data  <= 32'h0000_0000;
			rx_last  <= 1'b0;
			tail_r   <= 32'h0000_0000;
		end else begin
			case (state_r)
				bus_reset_pkg::GEN_IDLE: begin
					if (ctl.start) begin
						state_r  <= bus_reset_pkg::GEN_HEAD;
						rx_valid <= 1'b1;
						rx_data  <= 32'(`BRP_TCODE) << `BRP_TCODE_LSB;
						rx_last  <= 1'b0;
						// tag lets software tell it from received packets
						tail_r   <= (32'(ctl.evt_code) << `BRP_EVT_LSB)
							| (32'(ctl.generation) << `BRP_GEN_LSB);
					end
				end
				bus_reset_pkg::GEN_HEAD: begin
					// a full FIFO just holds the quadlet, nothing is dropped
					if (take) begin
						state_r <= bus_reset_pkg::GEN_TAIL;
						rx_data <= tail_r;
						rx_last <= 1'b1;
					end
				end
				bus_reset_pkg::GEN_TAIL: begin
					if (take) begin
						state_r  <= bus_reset_pkg::GEN_IDLE;
						rx_valid <= 1'b0;
						rx_last  <= 1'b0;
					end
				end
				default: begin
					state_r  <= bus_reset_pkg::GEN_IDLE;
					rx_valid <= 1'b0;
				end
			endcase
		end
	end
endmodule : bus_reset_packet_gen
`default_nettype wire

// ==== design/bus_reset_context_handling.sv ====
// Purpose: bus-reset handling of the asynchronous DMA contexts with an APB register file
// Assumes: inputs synchronous to pclk; transmit engine drops a retired packet's flag
// Notes: isochronous engines have no connection here at all
//
// Implementation choices: the APB slave port and the placing of the registers.
`include "bus_reset_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module bus_reset_context_handling #(
	parameter bus_reset_pkg::evt_code_t NO_ACK_CODE    = 5'h03,
	parameter bus_reset_pkg::evt_code_t FLUSHED_CODE   = 5'h0f,
	parameter bus_reset_pkg::evt_code_t BUS_RESET_CODE = 5'h09,
	parameter int                       NUM_AT         = 2
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// apb slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output var  logic [31:0]                prdata,
	output var  logic                       pready,
	output var  logic                       pslverr,
	output var  logic                       irq,
	// physical layer side
	input  wire logic                       phy_bus_reset,
	input  wire logic [7:0]                 phy_generation,
	input  wire logic                       node_id_valid,
	input  wire logic [5:0]                 node_number_field,
	// async transmit engine, inputs one bit per context
	input  wire logic [NUM_AT-1:0]          at_fifo_valid,
	input  wire logic [NUM_AT-1:0]          at_wait_ack,
	input  wire logic [NUM_AT-1:0]          at_dma_busy,
	input  wire logic [NUM_AT-1:0]          at_status_busy,
	output var  logic                       at_tx_enable,
	output var  logic                       at_retire_valid,
	output var  logic                       at_retire_ctx,
	output var  bus_reset_pkg::evt_code_t   at_retire_code,
	// async receive request context
	input  wire logic                       ar_dma_busy,
	input  wire logic                       ar_buf_space_ok,
	input  wire logic                       ar_req_pkt_written,
	input  wire logic                       rx_ready,
	output var  logic                       rx_valid,
	output var  bus_reset_pkg::quadlet_t    rx_data,
	output var  logic                       rx_last
);
	// register state
	logic [2:0]                 run_r;
	logic [2:0]                 active_r;
	logic [1:0]                 event_r;
	logic [1:0]                 mask_r;
	bus_reset_pkg::generation_t gen_r;
	logic                       phy_reset_q_r;
	logic                       brp_pend_r;

	// apb decode
	wire                        setup_ph;
	wire                        wr_fire;
	wire                        hit_run;
	wire                        hit_stat;
	wire                        hit_ev;
	wire                        hit_mask;
	wire                        hit_node;
	wire                        hit_sidc;
	wire                        mapped;
	wire [31:0]                 rd_word;
	wire                        wr_run;
	wire                        wr_ev;
	wire                        wr_mask;
	wire [31:0]                 rd_run;
	wire [31:0]                 rd_stat;
	wire [31:0]                 rd_ev;
	wire [31:0]                 rd_mask;
	wire [31:0]                 rd_node;
	wire [31:0]                 rd_sidc;

	// event logic
	wire                        reset_seen;
	wire [1:0]                  ev_set;
	wire [1:0]                  ev_clr;
	wire [1:0]                  event_nxt;
	wire                        flushing;
	wire [NUM_AT-1:0]           at_stable;
	wire                        ar_stable;
	wire [NUM_AT-1:0]           at_retire_pend;
	wire                        retire_go;
	wire                        retire_sel;
	wire                        brp_start;
	wire                        retire_any;
	wire                        ar_active;
	wire                        irq_nxt;
	wire                        tx_enable_nxt;

	brp_if brp ();

	// lowest-numbered context with something to retire
	function automatic logic pick_ctx(input logic [NUM_AT-1:0] req);
		logic sel;
		sel = 1'b0;
		for (int i = NUM_AT - 1; i >= 0; i--) begin
			if (req[i]) begin
				sel = i[0];
			end
		end
		return sel;
	endfunction : pick_ctx

	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
		return a == ofs;
	endfunction : addr_is

	assign setup_ph  = psel & ~penable;
	assign wr_fire   = psel & penable & pready & pwrite;
	assign hit_run   = addr_is(paddr, `OFS_RUN_CTRL);
	assign hit_stat  = addr_is(paddr, `OFS_CTX_STATUS);
	assign hit_ev    = addr_is(paddr, `OFS_INT_EVENT);
	assign hit_mask  = addr_is(paddr, `OFS_INT_MASK);
	assign hit_node  = addr_is(paddr, `OFS_NODE_ID);
	assign hit_sidc  = addr_is(paddr, `OFS_SELF_ID_CNT);
	assign mapped    = hit_run | hit_stat | hit_ev | hit_mask | hit_node | hit_sidc;

	assign wr_run  = wr_fire & hit_run;
	assign wr_ev   = wr_fire & hit_ev;
	assign wr_mask = wr_fire & hit_mask;

	// one word per register; unmapped offsets read as zero
	assign rd_run  = {29'h0, run_r};
	assign rd_stat = {26'h0, brp_pend_r, flushing, 1'b0, active_r};
	assign rd_ev   = {30'h0, event_r};
	assign rd_mask = {30'h0, mask_r};
	assign rd_node = ({31'h0, node_id_valid} << `NODE_VALID_BIT)
		| ({26'h0, node_number_field} << `NODE_NUM_LSB);
	assign rd_sidc = {24'h0, gen_r} << `SIDC_GEN_LSB;

	assign rd_word =
		hit_run  ? rd_run :
		hit_stat ? rd_stat :
		hit_ev   ? rd_ev :
		hit_mask ? rd_mask :
		hit_node ? rd_node :
		hit_sidc ? rd_sidc :
		32'h0000_0000;

	// a new rising indication is a fresh reset, even while one is pending
	assign reset_seen = phy_bus_reset & ~phy_reset_q_r;

	// bus_reset_event rises with detection, not with the packet's delivery
	assign ev_set[`EV_BUS_RESET] = reset_seen;
	// the bus-reset packet raises this through the same written strobe
	assign ev_set[`EV_REQ_PKT]   = ar_req_pkt_written;
	assign ev_clr    = wr_ev ? pwdata[1:0] : 2'b00;
	// set beats a same-cycle clear
	assign event_nxt = (event_r & ~ev_clr) | ev_set;

	// flushing lasts exactly as long as the event; software clears it late
	assign flushing = event_r[`EV_BUS_RESET];

	// irq and the transmit gate follow the next event value, so they move with it
	assign irq_nxt       = |(event_nxt & mask_r);
	assign tx_enable_nxt = ~event_nxt[`EV_BUS_RESET];

	// stable: no transfer, no status write, nothing left to retire
	assign at_stable = ~(at_dma_busy | at_status_busy | at_fifo_valid | at_wait_ack);
	assign ar_stable = ~ar_dma_busy & ~brp.busy & ~brp_pend_r;

	assign at_retire_pend = at_fifo_valid | at_wait_ack;
	assign retire_any     = |at_retire_pend;
	// one retirement every other cycle so the engine can drop its flag
	assign retire_go      = flushing & retire_any & ~at_retire_valid;
	assign retire_sel     = pick_ctx(at_retire_pend);

	// only into an active request context with host space
	assign ar_active = active_r[`CTX_AR_REQ];
	assign brp_start = brp_pend_r & ar_active & ar_buf_space_ok & ~brp.busy;

	assign brp.start      = brp_start;
	assign brp.generation = gen_r;
	assign brp.evt_code   = BUS_RESET_CODE;

	bus_reset_packet_gen u_gen (
		.pclk     (pclk),
		.presetn  (presetn),
		.ctl      (brp),
		.rx_ready (rx_ready),
		.rx_valid (rx_valid),
		.rx_data  (rx_data),
		.rx_last  (rx_last)
	);

	// apb answer: pready high for the first access cycle, so zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~mapped;
			if (setup_ph) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_word;
			end
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r  <= `RST_RUN;
			mask_r <= `RST_MASK;
		end else begin
			// run bits take the written value; a valid node number is not checked
			if (wr_run) begin
				run_r <= pwdata[2:0];
			end
			if (wr_mask) begin
				mask_r <= pwdata[1:0];
			end
		end
	end

	// events, generation, interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_r       <= 2'b00;
			phy_reset_q_r <= 1'b0;
			gen_r         <= 8'h00;
			irq           <= 1'b0;
		end else begin
			event_r       <= event_nxt;
			phy_reset_q_r <= phy_bus_reset;
			irq           <= irq_nxt;
			if (reset_seen) begin
				gen_r <= phy_generation;
			end
		end
	end

	// active flags follow run, and drop only once the context has settled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_r <= 3'b000;
		end else begin
			for (int c = 0; c < NUM_AT; c++) begin
				if (run_r[c]) begin
					active_r[c] <= 1'b1;
				end else if (at_stable[c]) begin
					active_r[c] <= 1'b0;
				end
			end
			if (run_r[`CTX_AR_REQ]) begin
				active_r[`CTX_AR_REQ] <= 1'b1;
			end else if (ar_stable) begin
				active_r[`CTX_AR_REQ] <= 1'b0;
			end
		end
	end

	// pending bus-reset packet: later resets fold into the one still waiting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brp_pend_r <= 1'b0;
		end else if (reset_seen) begin
			brp_pend_r <= 1'b1;
		end else if (brp_start) begin
			brp_pend_r <= 1'b0;
		end else if (~ar_active) begin
			brp_pend_r <= 1'b0; // an inactive context gets no packet
		end
	end

	// transmit gate: closed from detection until software clears the event
	// iso contexts are driven elsewhere and this gate never reaches them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			at_tx_enable <= 1'b1;
		end else begin
			at_tx_enable <= tx_enable_nxt;
		end
	end

	// flush retirement: one completion per pulse, sent-unacked first per context
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			at_retire_valid <= 1'b0;
			at_retire_ctx   <= 1'b0;
			at_retire_code  <= 5'h00;
		end else begin
			at_retire_valid <= retire_go;
			if (retire_go) begin
				at_retire_ctx <= retire_sel;
				if (at_wait_ack[retire_sel]) begin
					at_retire_code <= NO_ACK_CODE;
				end else begin
					at_retire_code <= FLUSHED_CODE;
				end
			end
		end
	end

endmodule : bus_reset_context_handling
`default_nettype wire

// ==== dv/brc_checker_assertions.sv ====
// Purpose: port-level checks of the bus-reset context block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every instance at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module brc_checker #(
	parameter bus_reset_pkg::evt_code_t NO_ACK_CODE    = 5'h03,
	parameter bus_reset_pkg::evt_code_t FLUSHED_CODE   = 5'h0f,
	parameter bus_reset_pkg::evt_code_t BUS_RESET_CODE = 5'h09,
	parameter int                       NUM_AT         = 2
) (
	input wire logic                     pclk,
	input wire logic                     presetn,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire logic                     phy_bus_reset,
	input wire logic [NUM_AT-1:0]        at_fifo_valid,
	input wire logic [NUM_AT-1:0]        at_wait_ack,
	input wire logic                     at_tx_enable,
	input wire logic                     at_retire_valid,
	input wire logic                     at_retire_ctx,
	input wire bus_reset_pkg::evt_code_t at_retire_code,
	input wire logic                     rx_valid,
	input wire logic                     rx_ready,
	input wire bus_reset_pkg::quadlet_t  rx_data,
	input wire logic                     rx_last
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// the code is chosen from what the engine showed one edge earlier
	logic [NUM_AT-1:0] ack_r;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) ack_r <= '0;
		else ack_r <= at_wait_ack;
	AST_TX_STOP: assert property (
		$rose(phy_bus_reset) |=> !at_tx_enable) else $error("transmit still enabled");
	AST_RETIRE_CODE: assert property (
		at_retire_valid |-> at_retire_code == (ack_r[at_retire_ctx] ? NO_ACK_CODE : FLUSHED_CODE))
		else $error("wrong retire code");
	AST_RETIRE_GATED: assert property (
		at_retire_valid |-> $past(at_tx_enable) == 1'b0) else $error("retire outside flush");
	AST_RETIRE_GAP: assert property (
		at_retire_valid |=> !at_retire_valid) else $error("retire pulses adjacent");
	AST_FLUSH_PROMPT: assert property (
		!at_tx_enable && (|(at_fifo_valid | at_wait_ack)) && !at_retire_valid |=> at_retire_valid)
		else $error("flush stalled");
	AST_RX_HOLD: assert property (
		rx_valid && !rx_ready |=> rx_valid && $stable(rx_data) && $stable(rx_last))
		else $error("quadlet dropped under stall");
	AST_RX_PAIR: assert property (
		rx_valid && rx_ready && !rx_last |-> rx_data[7:4] == 4'he
		##1 rx_valid && rx_last && rx_data[20:16] == BUS_RESET_CODE) else $error("bad packet");
	AST_APB_READY: assert property (
		psel && !penable |=> pready ##1 !pready) else $error("pready not one cycle");
	COV_NOACK: cover property (at_retire_valid && at_retire_code == NO_ACK_CODE);
	COV_PKT: cover property (rx_valid && rx_ready && rx_last);
	COV_ERR: cover property (pready && pslverr);
endmodule : brc_checker
bind bus_reset_context_handling brc_checker #(.NO_ACK_CODE(NO_ACK_CODE),
	.FLUSHED_CODE(FLUSHED_CODE), .BUS_RESET_CODE(BUS_RESET_CODE), .NUM_AT(NUM_AT)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .phy_bus_reset(phy_bus_reset), .at_fifo_valid(at_fifo_valid),
	.at_wait_ack(at_wait_ack), .at_tx_enable(at_tx_enable), .at_retire_valid(at_retire_valid),
	.at_retire_ctx(at_retire_ctx), .at_retire_code(at_retire_code), .rx_valid(rx_valid),
	.rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last));
`default_nettype wire

// ==== dv/at_link_model.sv ====
// Purpose: transmit engine and receive FIFO standing beside the block
// Assumes: loads are one-cycle pulses from the bench
// Notes: a retired packet's flag is dropped at the edge that sees the pulse
`timescale 1ns/1ps
`default_nettype none
module at_link_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] load_fifo,
	input  wire logic [1:0] load_ack,
	input  wire logic       at_retire_valid,
	input  wire logic       at_retire_ctx,
	output var  logic [1:0] at_fifo_valid,
	output var  logic [1:0] at_wait_ack,
	output var  logic [1:0] at_dma_busy,
	output var  logic [1:0] at_status_busy,
	output var  logic       rx_ready
);
	wire [1:0] ret = {at_retire_valid & at_retire_ctx, at_retire_valid & ~at_retire_ctx};
	assign at_dma_busy = at_fifo_valid | at_wait_ack;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			at_fifo_valid <= '0;
			at_wait_ack <= '0;
			at_status_busy <= '0;
			rx_ready <= 1'b0;
		end else begin
			// the sent packet is retired before the queued one
			at_wait_ack <= (at_wait_ack & ~ret) | load_ack;
			at_fifo_valid <= (at_fifo_valid & ~(ret & ~at_wait_ack)) | load_fifo;
			// status write keeps the context busy one cycle past the retire
			at_status_busy <= ret;
			rx_ready <= 1'($urandom_range(0, 1));
		end
	end
endmodule : at_link_model
`default_nettype wire

// ==== dv/bus_reset_context_handling_tb.sv ====
// Purpose: self-checking bench of the bus-reset context block
// Assumes: default event codes of the block
// Notes: results are checked in order against a queue of notes
`include "bus_reset_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module bus_reset_context_handling_tb;
	typedef struct packed {logic [31:0] exp; logic [31:0] msk;} note_t;
	localparam bus_reset_pkg::evt_code_t NO_ACK_CODE    = 5'h03;
	localparam bus_reset_pkg::evt_code_t FLUSHED_CODE   = 5'h0f;
	localparam bus_reset_pkg::evt_code_t BUS_RESET_CODE = 5'h09;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr, irq, phy_bus_reset;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  phy_generation, gen1, gen2;
	logic        node_id_valid, at_tx_enable, at_retire_valid, at_retire_ctx;
	logic [5:0]  node_number_field;
	logic [1:0]  load_fifo, load_ack, at_fifo_valid, at_wait_ack, at_dma_busy, at_status_busy;
	logic        ar_buf_space_ok, ar_req_pkt_written, rx_ready, rx_valid, rx_last, err_s;
	logic        ar_dma_busy;
	bus_reset_pkg::evt_code_t at_retire_code;
	bus_reset_pkg::quadlet_t  rx_data;
	int          n_errors = 0;
	int          num_checks = 0;
	int          cyc = 0;
	note_t       q[$];
	always #12.5 pclk = ~pclk;
	bus_reset_context_handling uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .phy_bus_reset(phy_bus_reset),
		.phy_generation(phy_generation), .node_id_valid(node_id_valid),
		.node_number_field(node_number_field), .at_fifo_valid(at_fifo_valid),
		.at_wait_ack(at_wait_ack), .at_dma_busy(at_dma_busy), .at_status_busy(at_status_busy),
		.at_tx_enable(at_tx_enable), .at_retire_valid(at_retire_valid),
		.at_retire_ctx(at_retire_ctx), .at_retire_code(at_retire_code),
		.ar_dma_busy(ar_dma_busy),
		.ar_buf_space_ok(ar_buf_space_ok), .ar_req_pkt_written(ar_req_pkt_written),
		.rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last));
	at_link_model far (.pclk(pclk), .presetn(presetn), .load_fifo(load_fifo),
		.load_ack(load_ack), .at_retire_valid(at_retire_valid), .at_retire_ctx(at_retire_ctx),
		.at_fifo_valid(at_fifo_valid), .at_wait_ack(at_wait_ack), .at_dma_busy(at_dma_busy),
		.at_status_busy(at_status_busy), .rx_ready(rx_ready));
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic take(string nm, logic [31:0] v);
		note_t n;
		if (q.size() == 0) begin
			n_errors++;
			$display("MISMATCH %s expected none seen %h", nm, v);
		end else begin
			n = q.pop_front();
			chk(nm, n.exp & n.msk, v & n.msk);
		end
	endtask : take
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite)
			take("prdata", prdata);
		if (at_retire_valid)
			take("retire", {26'h0, at_retire_ctx, at_retire_code});
		if (rx_valid && rx_ready)
			take("rx_data", rx_data);
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	// called just after a rising edge; returns one edge after the access
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		err_s = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(logic [11:0] a, logic [31:0] e, logic [31:0] m);
		q.push_back('{e, m});
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic reset_pulse(logic [7:0] g);
		phy_bus_reset <= 1'b1;
		phy_generation <= g;
		repeat (2) @(posedge pclk);
		phy_bus_reset <= 1'b0;
		@(posedge pclk);
	endtask : reset_pulse
	initial begin
		{presetn, psel, penable, pwrite, phy_bus_reset, node_id_valid} = '0;
		{paddr, pwdata, phy_generation, node_number_field} = '0;
		{load_fifo, load_ack, ar_buf_space_ok, ar_req_pkt_written, ar_dma_busy} = '0;
		void'($urandom(32'h231c6eb6));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`OFS_RUN_CTRL, 32'h0, 32'hffffffff);
		rd(`OFS_INT_MASK, 32'h0, 32'hffffffff);
		rd(12'h018, 32'h0, 32'hffffffff);
		chk("pslverr", 32'h1, {31'h0, err_s});
		chk("tx_enable", 32'h1, {31'h0, at_tx_enable});
		$display("test reset values done");
		apb(1'b1, `OFS_RUN_CTRL, 32'h7);
		apb(1'b1, `OFS_INT_MASK, 32'h3);
		rd(`OFS_CTX_STATUS, 32'h7, 32'h7);
		gen1 = 8'($urandom);
		gen2 = 8'($urandom);
		load_ack <= 2'b01;
		load_fifo <= 2'b10;
		q.push_back('{{27'h0, NO_ACK_CODE}, 32'h3f});
		q.push_back('{{26'h0, 1'b1, FLUSHED_CODE}, 32'h3f});
		@(posedge pclk);
		{load_ack, load_fifo} <= '0;
		reset_pulse(gen1);
		reset_pulse(gen2);
		repeat (6) @(posedge pclk);
		chk("tx_enable", 32'h0, {31'h0, at_tx_enable});
		chk("irq", 32'h1, {31'h0, irq});
		rd(`OFS_INT_EVENT, 32'h1, 32'h1);
		rd(`OFS_CTX_STATUS, 32'h20, 32'h20);
		rd(`OFS_SELF_ID_CNT, {8'h0, gen2, 16'h0}, 32'h00ff0000);
		chk("rx_valid", 32'h0, {31'h0, rx_valid});
		q.push_back('{32'he0, 32'hf0});
		q.push_back('{{11'h0, BUS_RESET_CODE, 8'h0, gen2}, 32'h1f00ff});
		ar_buf_space_ok <= 1'b1;
		while (q.size() != 0) @(posedge pclk);
		ar_req_pkt_written <= 1'b1;
		@(posedge pclk);
		ar_req_pkt_written <= 1'b0;
		@(posedge pclk);
		rd(`OFS_INT_EVENT, 32'h3, 32'h3);
		$display("test bus reset done");
		apb(1'b1, `OFS_RUN_CTRL, 32'h4);
		rd(`OFS_CTX_STATUS, 32'h4, 32'h27);
		apb(1'b1, `OFS_INT_EVENT, 32'h3);
		@(posedge pclk);
		chk("irq", 32'h0, {31'h0, irq});
		chk("tx_enable", 32'h1, {31'h0, at_tx_enable});
		load_fifo <= 2'b01;
		@(posedge pclk);
		load_fifo <= 2'b00;
		repeat (6) @(posedge pclk);
		chk("fifo_kept", 32'h1, {30'h0, at_fifo_valid});
		// a busy receive context keeps its active flag after run drops
		ar_dma_busy <= 1'b1;
		apb(1'b1, `OFS_RUN_CTRL, 32'h0);
		rd(`OFS_CTX_STATUS, 32'h4, 32'h7);
		ar_dma_busy <= 1'b0;
		@(posedge pclk);
		rd(`OFS_CTX_STATUS, 32'h0, 32'h7);
		node_id_valid <= 1'b1;
		node_number_field <= 6'($urandom_range(0, 62));
		@(posedge pclk);
		rd(`OFS_NODE_ID, {1'b1, 25'h0, node_number_field}, 32'h8000003f);
		if (node_id_valid && node_number_field != 6'h3f)
			apb(1'b1, `OFS_RUN_CTRL, 32'h7);
		rd(`OFS_RUN_CTRL, 32'h7, 32'h7);
		$display("test recovery done");
		wrap_up();
	end
endmodule : bus_reset_context_handling_tb
`default_nettype wire
